// File: verilog/csm_pkg.sv
// Purpose: shared types and constants for the skip, OR and move execution slice
// Assumes: instructions arrive already decoded, one per clock, from fetch logic
// Notes: widths here match the 8-bit core with a 128-byte register file
package csm_pkg;

   // ==========================================================
   // widths and sizes
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int FILE_DEPTH = 128;

   // ==========================================================
   // values used by the datapath
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [DATA_W-1:0] W_RESET = 8'h00;
   localparam logic Z_RESET = 1'h0;
   localparam logic DEST_W = 1'h0;   // result goes to the working register
   localparam logic DEST_F = 1'h1;   // result goes back to the data register

   // ==========================================================
   // decoded operation select; all other codes retire as no-operation
   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_DEC_SKIP = 3'h1,
      OP_INC_SKIP = 3'h2,
      OP_OR_LIT = 3'h3,
      OP_OR_REG = 3'h4,
      OP_LOAD_LIT = 3'h5,
      OP_STORE_W = 3'h6
   } csm_op_t;

   // decoded instruction word
   typedef struct packed {
      csm_op_t op;
      logic dest;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] literal;
   } csm_instr_t;

   // register-file write
   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } csm_wr_t;

endpackage

// File: verilog/csm_file.sv
// Purpose: data register file with one combinational read and one clocked write
// Assumes: a single writer; reset clears every entry
// Notes: read shows the old value in the cycle of a write to the same address
`timescale 1ns/1ns
`default_nettype none
module csm_file
   import csm_pkg::*;
#(
   parameter int DEPTH = FILE_DEPTH,
   parameter int WIDTH = DATA_W,
   parameter int AW = ADDR_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // write side
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read side
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } csm_file_st_t;

   csm_file_st_t st;
   csm_file_st_t next_st;

   // ==========================================================
   // storage update
   always_comb begin
      next_st = st;
      if (we) begin
         next_st.mem[waddr] = wdata;
      end
   end

   // reset clears the file so a bench never reads unknowns
   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.mem[raddr];

endmodule // csm_file
`default_nettype wire

// File: verilog/csm_core.sv
// Purpose: execution slice for skip-on-zero, OR and move operations of an 8-bit core
// Assumes: decoded instructions from same-clock fetch logic, at most one per cycle
// Notes: a taken skip discards the next presented instruction, raising SQUASH instead of RETIRE
//
// Notes on behaviour
// - decrement-skip subtracts one from the register, dest bit picks target, flags kept
// - decrement-skip with zero result replaces the next instruction by a no-op
// - increment-skip adds one to the register, dest bit picks target, flags kept
// - increment-skip with zero result replaces the next instruction by a no-op
// - OR-literal ORs working register with literal into working register, sets zero flag
// - OR-register ORs working with register, dest bit picks target, sets zero flag
// - load-literal copies literal into working register, flags kept, spare bits ignored
// - store copies working register into addressed data register, flags kept
`timescale 1ns/1ns
`default_nettype none
module csm_core
   import csm_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // instruction in
   input wire logic INSTR_VALID,
   input wire csm_instr_t INSTR,
   // architectural state out
   output logic [DATA_W-1:0] W_VALUE,
   output logic ZERO_FLAG,
   output logic SKIP_PENDING,
   // per-instruction status
   output logic RETIRE,
   output logic SQUASH,
   output csm_wr_t FILE_WR
);

   typedef struct packed {
      logic [DATA_W-1:0] w;
      logic z;
      logic skip;
      logic retire;
      logic squash;
      csm_wr_t wr;
   } csm_core_st_t;

   csm_core_st_t st;
   csm_core_st_t next_st;
   logic [DATA_W-1:0] rd_data;
   logic exec;

   // an instruction runs unless a pending skip swallows it
   assign exec = INSTR_VALID && !st.skip;

   // ==========================================================
   // register file
   csm_file #(
      .DEPTH(FILE_DEPTH),
      .WIDTH(DATA_W),
      .AW(ADDR_W)
   ) u_file (
      .clk(CLK_SYS),
      .srst(SRST),
      .we(next_st.wr.en),
      .waddr(next_st.wr.addr),
      .wdata(next_st.wr.data),
      .raddr(INSTR.addr),
      .rdata(rd_data)
   );

   // ==========================================================
   // execute: one instruction per cycle, result lands at the next edge
   always_comb begin
      logic [DATA_W-1:0] res;
      res = DATA_ZERO;
      next_st = st;
      next_st.retire = 1'b0;
      next_st.squash = 1'b0;
      next_st.wr = '0;
      if (INSTR_VALID) begin
         if (st.skip) begin
            // skipped slot: only the pending skip clears, it is flagged on SQUASH and does not retire
            next_st.skip = 1'b0;
            next_st.squash = 1'b1;
         end else begin
            next_st.retire = 1'b1;
            case (INSTR.op)
               OP_DEC_SKIP: begin
                  res = rd_data - DATA_ONE;
                  next_st.skip = (res == DATA_ZERO);
               end
               OP_INC_SKIP: begin
                  res = rd_data + DATA_ONE;
                  next_st.skip = (res == DATA_ZERO);
               end
               OP_OR_LIT: begin
                  res = st.w | INSTR.literal;
                  next_st.z = (res == DATA_ZERO);
               end
               OP_OR_REG: begin
                  res = st.w | rd_data;
                  next_st.z = (res == DATA_ZERO);
               end
               OP_LOAD_LIT: begin
                  res = INSTR.literal;
               end
               OP_STORE_W: begin
                  res = st.w;
               end
               default: begin
                  res = DATA_ZERO;
               end
            endcase
            // route the result; literal ops ignore dest and addr fields
            case (INSTR.op)
               OP_DEC_SKIP, OP_INC_SKIP, OP_OR_REG: begin
                  if (INSTR.dest == DEST_F) begin
                     next_st.wr = '{en: 1'b1, addr: INSTR.addr, data: res};
                  end else begin
                     next_st.w = res;
                  end
               end
               OP_OR_LIT, OP_LOAD_LIT: begin
                  next_st.w = res;
               end
               OP_STORE_W: begin
                  next_st.wr = '{en: 1'b1, addr: INSTR.addr, data: res};
               end
               default: begin
                  next_st.w = st.w;
               end
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         st <= '{w: W_RESET, z: Z_RESET, skip: 1'b0, retire: 1'b0, squash: 1'b0, wr: '0};
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign W_VALUE = st.w;
   assign ZERO_FLAG = st.z;
   assign SKIP_PENDING = st.skip;
   assign RETIRE = st.retire;
   assign SQUASH = st.squash;
   assign FILE_WR = st.wr;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SRST);

   AST_DEC_TO_W: assert property (
      exec && INSTR.op == OP_DEC_SKIP && INSTR.dest == DEST_W
      |=> W_VALUE == DATA_W'($past(rd_data) - DATA_ONE) && ZERO_FLAG == $past(ZERO_FLAG)
         && !FILE_WR.en)
      else $error("decrement to working register wrong");

   AST_DEC_SKIP: assert property (
      exec && INSTR.op == OP_DEC_SKIP
      |=> SKIP_PENDING == ($past(rd_data) == DATA_ONE))
      else $error("decrement skip decision wrong");

   AST_SQUASH: assert property (
      INSTR_VALID && SKIP_PENDING
      |=> SQUASH && !RETIRE && !SKIP_PENDING && !FILE_WR.en && $stable(W_VALUE)
         && $stable(ZERO_FLAG))
      else $error("skipped instruction not discarded");

   AST_INC_TO_F: assert property (
      exec && INSTR.op == OP_INC_SKIP && INSTR.dest == DEST_F
      |=> FILE_WR.en && FILE_WR.addr == $past(INSTR.addr)
         && FILE_WR.data == DATA_W'($past(rd_data) + DATA_ONE)
         && $stable(W_VALUE) && $stable(ZERO_FLAG))
      else $error("increment to register wrong");

   AST_INC_SKIP: assert property (
      exec && INSTR.op == OP_INC_SKIP && rd_data == 8'hff
      |=> SKIP_PENDING ##1 (SQUASH || !$past(INSTR_VALID) && SKIP_PENDING))
      else $error("increment skip not taken");

   AST_OR_LIT: assert property (
      exec && INSTR.op == OP_OR_LIT
      |=> W_VALUE == ($past(W_VALUE) | $past(INSTR.literal)) && !FILE_WR.en)
      else $error("or literal wrong");

   AST_OR_REG_F: assert property (
      exec && INSTR.op == OP_OR_REG && INSTR.dest == DEST_F
      |=> FILE_WR.en && FILE_WR.data == ($past(W_VALUE) | $past(rd_data))
         && $stable(W_VALUE))
      else $error("or register to file wrong");

   AST_LOAD_LIT: assert property (
      exec && INSTR.op == OP_LOAD_LIT
      |=> W_VALUE == $past(INSTR.literal) && $stable(ZERO_FLAG) && !SKIP_PENDING)
      else $error("load literal wrong");

   AST_STORE_W: assert property (
      exec && INSTR.op == OP_STORE_W
      |=> FILE_WR.en && FILE_WR.addr == $past(INSTR.addr) && FILE_WR.data == $past(W_VALUE)
         && $stable(ZERO_FLAG) && $stable(W_VALUE))
      else $error("store working register wrong");

   AST_ZERO_FLAG: assert property (
      exec && (INSTR.op == OP_OR_LIT || INSTR.op == OP_OR_REG)
      |=> ZERO_FLAG == ((FILE_WR.en ? FILE_WR.data : W_VALUE) == DATA_ZERO))
      else $error("zero flag does not follow result");

   AST_OR_REG_W: assert property (
      exec && INSTR.op == OP_OR_REG && INSTR.dest == DEST_W
      |=> W_VALUE == ($past(W_VALUE) | $past(rd_data)) && !FILE_WR.en)
      else $error("or register to working register wrong");

   AST_RETIRE: assert property (
      exec
      |=> RETIRE && !SQUASH)
      else $error("executed instruction did not retire");

   AST_IDLE: assert property (
      !INSTR_VALID
      |=> !RETIRE && !SQUASH && !FILE_WR.en && $stable(W_VALUE) && $stable(ZERO_FLAG)
         && $stable(SKIP_PENDING))
      else $error("idle cycle changed state");

   COV_DEC_SKIP: cover property (exec && INSTR.op == OP_DEC_SKIP && rd_data == DATA_ONE
      ##1 INSTR_VALID ##1 SQUASH);
   COV_INC_SKIP: cover property (exec && INSTR.op == OP_INC_SKIP && rd_data == 8'hff);
   COV_OR_ZERO: cover property (exec && INSTR.op == OP_OR_REG ##1 ZERO_FLAG);
   COV_STORE: cover property (exec && INSTR.op == OP_STORE_W ##1 FILE_WR.en);

endmodule // csm_core
`default_nettype wire

// File: verif/csm_tb.sv
// Purpose: self-checking bench for the skip, OR and move execution slice
// Assumes: mostly one instruction every other cycle, one scenario back to back;
//    file contents seen only on FILE_WR
// Notes: assertions live in the design files, so this bench only drives and compares
`timescale 1ns/1ns
`default_nettype none
module tb;
   import csm_pkg::*;
   // ==========================================================
   // clock, reset and design
   logic CLK_SYS = 1'b0;
   logic SRST = 1'b1;
   logic INSTR_VALID = 1'b0;
   csm_instr_t INSTR = '0;
   logic [DATA_W-1:0] W_VALUE;
   logic ZERO_FLAG, SKIP_PENDING, RETIRE, SQUASH;
   csm_wr_t FILE_WR;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #4 CLK_SYS = ~CLK_SYS;

   csm_core DUT (
      .CLK_SYS(CLK_SYS), .SRST(SRST), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
      .W_VALUE(W_VALUE), .ZERO_FLAG(ZERO_FLAG), .SKIP_PENDING(SKIP_PENDING),
      .RETIRE(RETIRE), .SQUASH(SQUASH), .FILE_WR(FILE_WR)
   );

   // ==========================================================
   // compare tasks and verdict
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e, input string m);
      chk8({7'h00, g}, {7'h00, e}, m);
   endtask

   // address and data only mean something while the write strobe is up
   task automatic chkwr(input csm_wr_t e);
      chk1(FILE_WR.en, e.en, "wr_en");
      if (e.en) begin
         chk8({1'b0, FILE_WR.addr}, {1'b0, e.addr}, "wr_addr");
         chk8(FILE_WR.data, e.data, "wr_data");
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // a hang would otherwise stall the run; the tests need well under 200 cycles
   always @(posedge CLK_SYS) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         err_count++;
         test_done();
      end
   end

   // ==========================================================
   // drive one instruction at the current edge and leave it standing
   task automatic drv(input csm_op_t op, input logic d, input logic [6:0] a, input logic [7:0] k);
      INSTR_VALID <= 1'b1;
      INSTR <= '{op, d, a, k};
   endtask

   // one instruction: presented at an edge, taken at the next, then judged
   task automatic ex(input csm_op_t op, input logic d, input logic [6:0] a, input logic [7:0] k);
      @(posedge CLK_SYS);
      drv(op, d, a, k);
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b0;
      #1;
   endtask

   task automatic post(input logic [7:0] w, input logic z, input logic sk, input logic ret,
                       input csm_wr_t wr);
      chk8(W_VALUE, w, "w");
      chk1(ZERO_FLAG, z, "zero");
      chk1(SKIP_PENDING, sk, "skip");
      chk1(RETIRE, ret, "retire");
      chk1(SQUASH, ~ret, "squash");
      chkwr(wr);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_move();
      ex(OP_LOAD_LIT, 1'b1, 7'h7f, 8'ha5);
      post(8'ha5, 1'b0, 1'b0, 1'b1, '0);
      ex(OP_STORE_W, 1'b0, 7'h7f, 8'h00);
      post(8'ha5, 1'b0, 1'b0, 1'b1, '{1'b1, 7'h7f, 8'ha5});
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h00);
      post(8'h00, 1'b0, 1'b0, 1'b1, '0);
      $display("test move done");
   endtask

   task automatic t_or();
      ex(OP_OR_LIT, 1'b0, 7'h00, 8'h00);
      post(8'h00, 1'b1, 1'b0, 1'b1, '0);
      ex(OP_OR_LIT, 1'b0, 7'h00, 8'h10);
      post(8'h10, 1'b0, 1'b0, 1'b1, '0);
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h81);
      ex(OP_STORE_W, 1'b0, 7'h03, 8'h00);
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h02);
      ex(OP_OR_REG, 1'b0, 7'h03, 8'h00);
      post(8'h83, 1'b0, 1'b0, 1'b1, '0);
      ex(OP_OR_REG, 1'b1, 7'h03, 8'h00);
      post(8'h83, 1'b0, 1'b0, 1'b1, '{1'b1, 7'h03, 8'h83});
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h00);
      ex(OP_OR_REG, 1'b1, 7'h04, 8'h00);
      post(8'h00, 1'b1, 1'b0, 1'b1, '{1'b1, 7'h04, 8'h00});
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h02);
      post(8'h02, 1'b1, 1'b0, 1'b1, '0);
      $display("test or done");
   endtask

   // zero flag is left at one here, so a skip op that touched it would show
   task automatic t_dec();
      ex(OP_STORE_W, 1'b0, 7'h05, 8'h00);
      ex(OP_DEC_SKIP, 1'b1, 7'h05, 8'h00);
      post(8'h02, 1'b1, 1'b0, 1'b1, '{1'b1, 7'h05, 8'h01});
      ex(OP_DEC_SKIP, 1'b1, 7'h05, 8'h00);
      post(8'h02, 1'b1, 1'b1, 1'b1, '{1'b1, 7'h05, 8'h00});
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h55);
      post(8'h02, 1'b1, 1'b0, 1'b0, '0);
      ex(OP_DEC_SKIP, 1'b0, 7'h05, 8'h00);
      post(8'hff, 1'b1, 1'b0, 1'b1, '0);
      $display("test dec done");
   endtask

   task automatic t_inc();
      ex(OP_STORE_W, 1'b0, 7'h06, 8'h00);
      ex(OP_INC_SKIP, 1'b0, 7'h06, 8'h00);
      post(8'h00, 1'b1, 1'b1, 1'b1, '0);
      repeat (3) @(posedge CLK_SYS);
      #1 chk1(SKIP_PENDING, 1'b1, "skip_idle");
      ex(OP_OR_LIT, 1'b0, 7'h00, 8'h30);
      post(8'h00, 1'b1, 1'b0, 1'b0, '0);
      ex(OP_INC_SKIP, 1'b1, 7'h06, 8'h00);
      post(8'h00, 1'b1, 1'b1, 1'b1, '{1'b1, 7'h06, 8'h00});
      ex(OP_STORE_W, 1'b0, 7'h07, 8'h00);
      post(8'h00, 1'b1, 1'b0, 1'b0, '0);
      ex(OP_INC_SKIP, 1'b1, 7'h06, 8'h00);
      post(8'h00, 1'b1, 1'b0, 1'b1, '{1'b1, 7'h06, 8'h01});
      ex(OP_LOAD_LIT, 1'b0, 7'h00, 8'h5a);
      post(8'h5a, 1'b1, 1'b0, 1'b1, '0);
      $display("test inc done");
   endtask

   // back to back: a write is read by the very next instruction, a skip eats the next one
   task automatic t_b2b();
      @(posedge CLK_SYS);
      drv(OP_STORE_W, 1'b0, 7'h09, 8'h00);
      @(posedge CLK_SYS);
      drv(OP_INC_SKIP, 1'b0, 7'h09, 8'h00);
      #1 post(8'h5a, 1'b1, 1'b0, 1'b1, '{1'b1, 7'h09, 8'h5a});
      @(posedge CLK_SYS);
      drv(OP_DEC_SKIP, 1'b0, 7'h06, 8'h00);
      #1 post(8'h5b, 1'b1, 1'b0, 1'b1, '0);
      @(posedge CLK_SYS);
      drv(OP_LOAD_LIT, 1'b0, 7'h00, 8'h11);
      #1 post(8'h00, 1'b1, 1'b1, 1'b1, '0);
      @(posedge CLK_SYS);
      drv(OP_LOAD_LIT, 1'b0, 7'h00, 8'h22);
      #1 post(8'h00, 1'b1, 1'b0, 1'b0, '0);
      @(posedge CLK_SYS);
      INSTR_VALID <= 1'b0;
      #1 post(8'h22, 1'b1, 1'b0, 1'b1, '0);
      $display("test b2b done");
   endtask

   // the no-op and undefined codes retire and touch nothing, even with dest and addr set
   task automatic t_odd();
      ex(OP_NOP, 1'b1, 7'h05, 8'hff);
      post(8'h22, 1'b1, 1'b0, 1'b1, '0);
      ex(csm_op_t'(3'h7), 1'b1, 7'h05, 8'h00);
      post(8'h22, 1'b1, 1'b0, 1'b1, '0);
      $display("test odd done");
   endtask

   // reset in mid-run must drop a pending skip and clear the file
   task automatic t_reset();
      ex(OP_DEC_SKIP, 1'b0, 7'h06, 8'h00);
      post(8'h00, 1'b1, 1'b1, 1'b1, '0);
      @(posedge CLK_SYS);
      SRST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      SRST <= 1'b0;
      #1;
      chk8(W_VALUE, W_RESET, "w_midreset");
      chk1(ZERO_FLAG, Z_RESET, "z_midreset");
      chk1(SKIP_PENDING | RETIRE | SQUASH | FILE_WR.en, 1'b0, "pulses_midreset");
      ex(OP_INC_SKIP, 1'b0, 7'h06, 8'h00);
      post(8'h01, 1'b0, 1'b0, 1'b1, '0);
      $display("test reset done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge CLK_SYS);
      SRST <= 1'b0;
      #1;
      chk8(W_VALUE, W_RESET, "w_reset");
      chk1(ZERO_FLAG, Z_RESET, "z_reset");
      chk1(SKIP_PENDING | RETIRE | SQUASH | FILE_WR.en, 1'b0, "pulses_reset");
      t_move();
      t_or();
      t_dec();
      t_inc();
      t_b2b();
      t_odd();
      t_reset();
      test_done();
   end
endmodule // tb
`default_nettype wire
